// ===== ddc_pkg.sv
// Constants for the digital down converter: register map, fields, resets.
// Assumes a single sample clock shared by converter core, registers and output.
package ddc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] freq_addr = 8'h04;
  localparam logic [7:0] active_freq_addr = 8'h08;
  localparam logic [7:0] status_addr = 8'h0c;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_mode_lsb = 1;
  localparam int ctrl_decim_lsb = 3;
  localparam int ctrl_gain_bit = 6;
  localparam int ctrl_invert_bit = 7;
  localparam int ctrl_restart_bit = 8;
  localparam int ctrl_width = 9;
  localparam logic [8:0] ctrl_reset = 9'h000;
  localparam logic [31:0] freq_reset = 32'h0000_0000;

  // Mode codes
  localparam logic [1:0] mode_complex = 2'h0;
  localparam logic [1:0] mode_real = 2'h1;
  localparam logic [1:0] mode_quarter = 2'h2;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  localparam int sample_width = 18;
  localparam int calc_width = 20;
  localparam int lut_frac = 15;
  localparam int max_decim_log2 = 5;
  localparam logic [2:0] max_decim_sel = 3'h4;
  localparam logic [8:0] root2_q7 = 9'h0b5;
  localparam int root2_frac = 7;

endpackage

// ===== ddc.sv
// Down converter datapath, its register file and the output FIFO.
// Samples arrive on the sample clock with valid/ready; sync comes from a pin.
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Output FIFO
// ----------------------------------------------------------------
module ddc_fifo #(
  parameter int width = 42,
  parameter int depth = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Fill side
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [width-1:0] s_data,
  // Drain side
  output logic m_valid,
  input wire logic m_ready,
  output logic [width-1:0] m_data,
  // Fill level
  output logic [$clog2(depth+1)-1:0] level
);
  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr;
  logic [aw-1:0] rd_ptr;
  logic [aw:0] count;
  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;

  assign s_ready = (count != depth[aw:0]);
  assign m_valid = (count != '0);
  assign m_data = mem[rd_ptr];
  assign level = count;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= s_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + {{aw{1'b0}}, push} - {{aw{1'b0}}, pop};
    end
  end
endmodule

// ----------------------------------------------------------------
// Down converter top
// ----------------------------------------------------------------
module ddc
  import ddc_pkg::*;
#(
  parameter int fifo_depth = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Converter sample stream
  input wire logic [sample_width-1:0] in_sample,
  input wire logic in_valid,
  output logic in_ready,
  // External sync pin
  input wire logic sync_pin,
  // Output stream
  output logic [calc_width-1:0] out_first,
  output logic [calc_width-1:0] out_second,
  output logic [1:0] out_mode,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int fifo_width = 2 * calc_width + 2;
  localparam int acc_width = calc_width + max_decim_log2;
  localparam int lw = $clog2(fifo_depth + 1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [ctrl_width-1:0] ctrl;
  logic [31:0] freq_word;
  logic [31:0] active_word;
  logic [31:0] phase;
  logic restart_seen;
  logic sync_meta;
  logic sync_sync;
  logic sync_prev;
  logic [31:0] rdata_hold;
  logic rd_pending;
  logic [lw-1:0] fifo_level;

  wire enable = ctrl[ctrl_enable_bit];
  wire [1:0] mode = ctrl[ctrl_mode_lsb +: 2];
  wire [2:0] decim_raw = ctrl[ctrl_decim_lsb +: 3];
  wire [2:0] decim_sel = (decim_raw > max_decim_sel) ? max_decim_sel : decim_raw;
  wire gain_en = ctrl[ctrl_gain_bit];
  wire invert = ctrl[ctrl_invert_bit];
  wire is_real = (mode == mode_real);

  wire wr_ctrl = reg_wr && (reg_addr == ctrl_addr);
  wire wr_freq = reg_wr && (reg_addr == freq_addr);
  // Either edge of the bit or the pin counts as a toggle
  wire restart = (ctrl[ctrl_restart_bit] != restart_seen) || (sync_sync != sync_prev);

  wire [31:0] rd_mux =
    (reg_addr == ctrl_addr) ? {{(32-ctrl_width){1'b0}}, ctrl} :
    (reg_addr == freq_addr) ? freq_word :
    (reg_addr == active_freq_addr) ? active_word :
    (reg_addr == status_addr) ? {{(32-lw-1){1'b0}}, fifo_level, in_ready} :
    32'h0000_0000;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= ctrl_reset;
      freq_word <= freq_reset;
      rd_pending <= 1'b0;
      rdata_hold <= 32'h0000_0000;
    end else begin
      ctrl <= wr_ctrl ? reg_wdata[ctrl_width-1:0] : ctrl;
      freq_word <= wr_freq ? reg_wdata : freq_word;
      rd_pending <= reg_rd;
      rdata_hold <= reg_rd ? rd_mux : rdata_hold;
    end
  end

  assign reg_rdata = rd_pending ? rdata_hold : 32'h0000_0000;

  // Pin passes two flops before the edge compare
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= sync_pin;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator
  // ----------------------------------------------------------------
  // Phase restarts at zero so both rails line up after a retune
  wire adv = in_valid && in_ready && enable;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_word <= freq_reset;
      phase <= 32'h0000_0000;
      restart_seen <= 1'b0;
    end else begin
      restart_seen <= ctrl[ctrl_restart_bit];
      active_word <= restart ? freq_word : active_word;
      // Signed word wraps modulo 2^32, covering minus to plus half rate
      phase <= restart ? 32'h0000_0000 : (adv ? phase + active_word : phase);
    end
  end

  // Quarter wave of cosine, 17 points, scaled to 2^15
  function automatic logic signed [16:0] quarter_cos(input logic [4:0] k);
    logic [15:0] v;
    v = 16'h0000;
    unique case (k)
      5'd0: v = 16'h7fff;
      5'd1: v = 16'h7f62;
      5'd2: v = 16'h7d8a;
      5'd3: v = 16'h7a7d;
      5'd4: v = 16'h7642;
      5'd5: v = 16'h70e3;
      5'd6: v = 16'h6a6e;
      5'd7: v = 16'h62f2;
      5'd8: v = 16'h5a82;
      5'd9: v = 16'h5134;
      5'd10: v = 16'h471d;
      5'd11: v = 16'h3c57;
      5'd12: v = 16'h30fc;
      5'd13: v = 16'h2528;
      5'd14: v = 16'h18f9;
      5'd15: v = 16'h0c8c;
      default: v = 16'h0000;
    endcase
    return signed'({1'b0, v});
  endfunction

  function automatic logic signed [16:0] cos64(input logic [5:0] idx);
    logic [4:0] k;
    logic [4:0] kr;
    k = {1'b0, idx[3:0]};
    kr = 5'd16 - k;
    unique case (idx[5:4])
      2'd0: return quarter_cos(k);
      2'd1: return -quarter_cos(kr);
      2'd2: return -quarter_cos(k);
      default: return quarter_cos(kr);
    endcase
  endfunction

  wire [5:0] cos_idx = phase[31:26];
  wire [5:0] sin_idx = phase[31:26] - 6'h10;
  wire signed [16:0] nco_cos = cos64(cos_idx);
  // Inverted phase conjugates the exponential
  wire signed [16:0] nco_sin = invert ? -cos64(sin_idx) : cos64(sin_idx);

  // ----------------------------------------------------------------
  // Mixer
  // ----------------------------------------------------------------
  wire signed [calc_width-1:0] x = calc_width'(signed'(in_sample));
  wire signed [calc_width+16:0] prod_i = x * nco_cos;
  wire signed [calc_width+16:0] prod_q = x * nco_sin;
  // Real mode skips the multipliers entirely
  wire signed [calc_width-1:0] mix_i = is_real ? x : calc_width'(prod_i >>> lut_frac);
  wire signed [calc_width-1:0] mix_q = is_real ? '0 : calc_width'(prod_q >>> lut_frac);

  // ----------------------------------------------------------------
  // Decimating low-pass (integrate and dump)
  // ----------------------------------------------------------------
  // Boxcar keeps area small; its sidelobes fall short of a long FIR
  logic signed [acc_width-1:0] acc_i;
  logic signed [acc_width-1:0] acc_q;
  logic [max_decim_log2-1:0] tap_count;
  wire [max_decim_log2-1:0] last_tap =
    max_decim_log2'((6'h02 << decim_sel) - 6'h01);
  wire dump = adv && (tap_count == last_tap);
  wire signed [acc_width-1:0] sum_i = acc_i + acc_width'(mix_i);
  wire signed [acc_width-1:0] sum_q = acc_q + acc_width'(mix_q);
  // Same window in real mode: real rate halves the usable bandwidth
  wire signed [acc_width-1:0] avg_i = sum_i >>> (decim_sel + 3'h1);
  wire signed [acc_width-1:0] avg_q = sum_q >>> (decim_sel + 3'h1);

  function automatic logic signed [calc_width-1:0] sat(input logic signed [acc_width+9:0] v);
    logic signed [acc_width+9:0] hi;
    logic signed [acc_width+9:0] lo;
    hi = (acc_width+10)'({1'b0, {(calc_width-1){1'b1}}});
    lo = -hi - 1;
    if (v > hi) begin
      return calc_width'(hi);
    end else if (v < lo) begin
      return calc_width'(lo);
    end
    return calc_width'(v);
  endfunction

  function automatic logic signed [calc_width-1:0] gain(input logic signed [acc_width-1:0] v,
                                                         input logic en, input logic real_mode);
    logic signed [acc_width+9:0] w;
    w = (acc_width+10)'(v);
    if (en && real_mode) begin
      return sat((w * signed'({1'b0, root2_q7})) >>> root2_frac);
    end else if (en) begin
      return sat(w <<< 1);
    end
    return sat(w);
  endfunction

  wire signed [calc_width-1:0] out_i = gain(avg_i, gain_en, is_real);
  wire signed [calc_width-1:0] out_q = gain(avg_q, gain_en, is_real);

  always_ff @(posedge clock) begin
    if (sys_rst || !enable) begin
      acc_i <= '0;
      acc_q <= '0;
      tap_count <= '0;
    end else if (adv) begin
      acc_i <= dump ? '0 : sum_i;
      acc_q <= dump ? '0 : sum_q;
      tap_count <= dump ? '0 : tap_count + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Quarter-rate rotation
  // ----------------------------------------------------------------
  // Pair m alternates (I, -Q) and (-I, Q): two real samples per pair
  logic rot_half;
  always_ff @(posedge clock) begin
    if (sys_rst || !enable) begin
      rot_half <= 1'b0;
    end else if (dump && mode == mode_quarter) begin
      rot_half <= ~rot_half;
    end
  end

  wire signed [calc_width-1:0] neg_i = sat(-(acc_width+10)'(out_i));
  wire signed [calc_width-1:0] neg_q = sat(-(acc_width+10)'(out_q));
  wire [calc_width-1:0] first_word =
    (mode == mode_quarter && rot_half) ? neg_i : out_i;
  wire [calc_width-1:0] second_word =
    (mode == mode_quarter) ? (rot_half ? out_q : neg_q) :
    (is_real ? '0 : out_q);

  // ----------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------
  logic fifo_ready;
  logic [fifo_width-1:0] fifo_out;

  // A full FIFO stalls the sample stream while enabled
  assign in_ready = fifo_ready || !enable;

  ddc_fifo #(
    .width(fifo_width),
    .depth(fifo_depth)
  ) ddc_fifo_inst (
    .clock(clock),
    .sys_rst(sys_rst),
    .s_valid(dump),
    .s_ready(fifo_ready),
    .s_data({mode, first_word, second_word}),
    .m_valid(out_valid),
    .m_ready(out_ready),
    .m_data(fifo_out),
    .level(fifo_level)
  );

  assign out_mode = fifo_out[fifo_width-1 -: 2];
  assign out_first = fifo_out[2*calc_width-1 -: calc_width];
  assign out_second = fifo_out[calc_width-1:0];
endmodule

// ===== ddc_props.sv
// Port checker for the down converter top.
// Assumes a bind onto ddc; one clock, synchronous reset.
`timescale 1ns/10ps
module ddc_props
  import ddc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sample stream and sync
  input wire logic [sample_width-1:0] in_sample,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic sync_pin,
  // Output stream
  input wire logic [calc_width-1:0] out_first,
  input wire logic [calc_width-1:0] out_second,
  input wire logic [1:0] out_mode,
  input wire logic out_valid,
  input wire logic out_ready
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rst_state; $fell(sys_rst) |-> !out_valid && in_ready && reg_rdata == 32'h0; endproperty
  a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_unmapped; reg_rd && reg_addr == 8'h10 |=> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_full; !in_ready |-> out_valid; endproperty
  a_full: assert property (p_full) else $error("refusing with empty buffer");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable({out_first, out_second}); endproperty
  a_hold: assert property (p_hold) else $error("head changed while stalled");
  property p_mode; out_valid |-> out_mode != 2'h3; endproperty
  a_mode: assert property (p_mode) else $error("illegal output mode");
  property p_real_q; out_valid && out_mode == mode_real |-> out_second == '0; endproperty
  a_real_q: assert property (p_real_q) else $error("real entry with second word");
  property p_no_push; !out_valid && !(in_valid && in_ready) |=> !out_valid; endproperty
  a_no_push: assert property (p_no_push) else $error("entry without sample");
  property p_pop_full; !in_ready && out_ready |=> in_ready; endproperty
  a_pop_full: assert property (p_pop_full) else $error("still full after pop");
endmodule

// ===== ddc_partner.sv
// Converter core source and output sink for the down converter.
// Assumes tasks are called from the bench, one at a time.
`timescale 1ns/10ps
module ddc_partner
  import ddc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Sample source
  output logic [sample_width-1:0] in_sample,
  output logic in_valid,
  input wire logic in_ready,
  // Output sink
  input wire logic [calc_width-1:0] out_first,
  input wire logic [calc_width-1:0] out_second,
  input wire logic [1:0] out_mode,
  input wire logic out_valid,
  output logic out_ready
);
  initial begin
    in_sample = 18'h00000;
    in_valid = 1'b0;
    out_ready = 1'b0;
  end
  // Idle line shows the inverse, so a stale sample cannot pass
  task automatic send(input int n, input logic [sample_width-1:0] x);
    @(posedge clock);
    repeat (n) begin
      in_valid <= 1'b1;
      in_sample <= x;
      do @(negedge clock); while (in_ready !== 1'b1);
      @(posedge clock);
    end
    in_valid <= 1'b0;
    in_sample <= ~x;
  endtask
  task automatic take(output logic [calc_width-1:0] a, b, output logic [1:0] m);
    @(posedge clock);
    out_ready <= 1'b1;
    do @(negedge clock); while (out_valid !== 1'b1);
    a = out_first;
    b = out_second;
    m = out_mode;
    @(posedge clock);
    out_ready <= 1'b0;
  endtask
endmodule

// ===== ddc_tb.sv
// Self-checking bench for the down converter top.
// Assumes ddc_partner as source and sink; FIFO shrunk to 4.
`timescale 1ns/10ps
module ddc_tb
  import ddc_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sync_pin = 1'b0;
  logic [31:0] reg_rdata;
  logic [sample_width-1:0] in_sample;
  logic in_valid, in_ready, out_valid, out_ready;
  logic [calc_width-1:0] out_first, out_second;
  logic [1:0] out_mode;
  logic tog = 1'b0;
  logic [2:0] dsel_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int n_mismatch = 0;
  int comparisons = 0;
  int n, sg;
  ddc #(.fifo_depth(4)) ddc_inst (.*);
  ddc_partner ddc_partner_inst (.*);
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic miss(input string s);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    comparisons++;
    if (reg_rdata !== e) miss($sformatf("reg %h read %h", a, reg_rdata));
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    comparisons++;
    if (g !== e) miss("flag level");
  endtask
  task automatic cmp_out(input int ea, input int eb, input logic [1:0] em, input int tol);
    logic [calc_width-1:0] a, b;
    logic [1:0] m;
    int da, db;
    ddc_partner_inst.take(a, b, m);
    da = int'($signed(a)) - ea;
    db = int'($signed(b)) - eb;
    comparisons++;
    if ((^{a, b}) === 1'bx || m !== em || da * da > tol * tol || db * db > tol * tol)
      miss($sformatf("output %h %h mode %h", a, b, m));
  endtask
  // Restart flips the toggle bit, every other write keeps it
  task automatic cfg(input logic [1:0] md, input logic [2:0] ds, input logic g, inv, rs);
    logic [31:0] c;
    if (rs) tog = ~tog;
    c = 32'h0000_0001;
    c[ctrl_mode_lsb +: 2] = md;
    c[ctrl_decim_lsb +: 3] = ds;
    c[ctrl_gain_bit] = g;
    c[ctrl_invert_bit] = inv;
    c[ctrl_restart_bit] = tog;
    wr(ctrl_addr, c);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    miss("watchdog ran out");
    finish_test();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rd(ctrl_addr, 32'h0000_0000);
    rd(status_addr, 32'h0000_0001);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0000);
    wr(freq_addr, 32'h4000_0000);
    rd(active_freq_addr, 32'h0000_0000);
    wr(active_freq_addr, 32'h0000_1234);
    cfg(mode_real, 3'h0, 1'b0, 1'b0, 1'b1);
    rd(active_freq_addr, 32'h4000_0000);
    $display("test restart bit done");
    foreach (dsel_tab[i]) begin
      cfg(mode_real, dsel_tab[i], 1'b0, 1'b0, 1'b0);
      n = (dsel_tab[i] > 3'h4) ? 32 : (2 << dsel_tab[i]);
      ddc_partner_inst.send(n - 1, 18'h00064);
      repeat (2) @(posedge clock);
      #1 cmp_flag(out_valid, 1'b0);
      ddc_partner_inst.send(1, 18'h00064);
      cmp_out(100, 0, mode_real, 0);
    end
    cfg(mode_real, 3'h0, 1'b1, 1'b0, 1'b0);
    ddc_partner_inst.send(2, 18'h00080);
    cmp_out(181, 0, mode_real, 0);
    $display("test real decimation done");
    wr(freq_addr, freq_reset);
    @(posedge clock);
    sync_pin <= 1'b1;
    repeat (8) @(posedge clock);
    rd(active_freq_addr, 32'h0000_0000);
    cfg(mode_complex, 3'h0, 1'b0, 1'b0, 1'b0);
    ddc_partner_inst.send(2, 18'h003e8);
    cmp_out(1000, 0, mode_complex, 2);
    cfg(mode_complex, 3'h0, 1'b1, 1'b0, 1'b0);
    ddc_partner_inst.send(2, 18'h003e8);
    cmp_out(2000, 0, mode_complex, 4);
    cfg(mode_quarter, 3'h0, 1'b0, 1'b0, 1'b0);
    ddc_partner_inst.send(6, 18'h003e8);
    cmp_out(1000, 0, mode_quarter, 2);
    cmp_out(-1000, 0, mode_quarter, 2);
    cmp_out(1000, 0, mode_quarter, 2);
    $display("test complex and quarter done");
    for (int k = 0; k < 3; k++) begin
      wr(freq_addr, (k == 2) ? 32'hc000_0000 : 32'h4000_0000);
      cfg(mode_complex, 3'h0, 1'b0, k == 1, 1'b1);
      sg = (k == 0) ? 1 : -1;
      ddc_partner_inst.send(4, 18'h003e8);
      cmp_out(500, 500 * sg, mode_complex, 4);
      cmp_out(-500, -500 * sg, mode_complex, 4);
    end
    // Disable clears the rotation phase; restart bit kept so no retune here
    wr(ctrl_addr, {23'h000000, tog, 8'h00});
    wr(freq_addr, 32'h4000_0000);
    cfg(mode_quarter, 3'h0, 1'b0, 1'b0, 1'b1);
    ddc_partner_inst.send(4, 18'h003e8);
    cmp_out(500, -500, mode_quarter, 4);
    cmp_out(500, -500, mode_quarter, 4);
    $display("test rotation done");
    cfg(mode_real, 3'h0, 1'b0, 1'b0, 1'b0);
    ddc_partner_inst.send(8, 18'h3ff00);
    #1 cmp_flag(in_ready, 1'b0);
    rd(status_addr, 32'h0000_0008);
    repeat (4) cmp_out(-256, 0, mode_real, 0);
    #1 cmp_flag(out_valid, 1'b0);
    rd(status_addr, 32'h0000_0001);
    $display("test buffer done");
    finish_test();
  end
endmodule

bind ddc ddc_props ddc_props_inst (.*);
